// ==== core/fdtc_pkg.sv ====
// Constants, types and helpers shared by the FDDI transmit conditioner
package fdtc_pkg;
  localparam int         FDTC_SYM_W      = 5;
  localparam int         FDTC_PAIR_W     = 10;
  localparam int         FDTC_ADDR_W     = 8;
  localparam int         FDTC_TM_W       = 3;
  localparam int         FDTC_IC_W       = 2;
  localparam int         FDTC_THR_W      = 8;
  localparam logic [3:0] FDTC_SLOT_FIRST = 4'h0;
  localparam logic [3:0] FDTC_SLOT_REDO  = 4'h1;
  localparam logic [3:0] FDTC_SLOT_LAST  = 4'h9;

  // Line symbols in 5B code
  localparam logic [4:0] FDTC_SYM_I = 5'h1f;
  localparam logic [4:0] FDTC_SYM_J = 5'h18;
  localparam logic [4:0] FDTC_SYM_K = 5'h11;
  localparam logic [4:0] FDTC_SYM_T = 5'h0d;
  localparam logic [4:0] FDTC_SYM_R = 5'h07;
  localparam logic [4:0] FDTC_SYM_S = 5'h19;
  localparam logic [4:0] FDTC_SYM_H = 5'h04;
  localparam logic [4:0] FDTC_SYM_Q = 5'h00;

  localparam logic [3:0] FDTC_PRE_TARGET = 4'h7;
  localparam logic [3:0] FDTC_PRE_SAT    = 4'hf;
  localparam logic [7:0] FDTC_INJ_SAT    = 8'hff;
  localparam logic [7:0] FDTC_INJ_ONE    = 8'h01;

  // Register byte offsets
  localparam logic [7:0] FDTC_OFS_TXSTATE = 8'h00;
  localparam logic [7:0] FDTC_OFS_INJCTL  = 8'h04;
  localparam logic [7:0] FDTC_OFS_THRESH  = 8'h08;
  localparam logic [7:0] FDTC_OFS_INJA    = 8'h0c;
  localparam logic [7:0] FDTC_OFS_INJB    = 8'h10;
  localparam logic [7:0] FDTC_OFS_MODE    = 8'h14;
  localparam logic [7:0] FDTC_OFS_STATUS  = 8'h18;

  // Field positions
  localparam int FDTC_TM_LSB      = 0;
  localparam int FDTC_IC_LSB      = 0;
  localparam int FDTC_SE_BIT      = 0;
  localparam int FDTC_PLAIN_BIT   = 6;
  localparam int FDTC_ST_RF_LSB   = 0;
  localparam int FDTC_ST_CNT_LSB  = 4;
  localparam int FDTC_ST_TM_LSB   = 8;
  localparam int FDTC_ST_IC_LSB   = 12;

  typedef enum logic [2:0] {
    FDTC_TM_ACTIVE = 3'h0, FDTC_TM_OFF = 3'h1, FDTC_TM_IDLE = 3'h2, FDTC_TM_MASTER = 3'h3,
    FDTC_TM_QUIET = 3'h4, FDTC_TM_RSVD = 3'h5, FDTC_TM_HALT = 3'h6, FDTC_TM_RSVD2 = 3'h7
  } fdtc_tm_t;

  typedef enum logic [1:0] {
    FDTC_IC_NONE = 2'h0, FDTC_IC_ONESHOT = 2'h1, FDTC_IC_PERIODIC = 2'h2, FDTC_IC_CONT = 2'h3
  } fdtc_ic_t;

  // Gray order along idle -> repeat -> end -> halt
  typedef enum logic [1:0] {
    FDTC_RF_IDLE = 2'h0, FDTC_RF_REPEAT = 2'h1, FDTC_RF_END = 2'h3, FDTC_RF_HALT = 2'h2
  } fdtc_rf_t;

  localparam fdtc_tm_t   FDTC_TM_RST    = FDTC_TM_OFF;
  localparam fdtc_ic_t   FDTC_IC_RST    = FDTC_IC_NONE;
  localparam logic       FDTC_SE_RST    = 1'b1;
  localparam logic       FDTC_PLAIN_RST = 1'b0;

  typedef struct packed {
    logic [3:0]             slot;
    logic                   redo;
    fdtc_rf_t               rf_st;
    logic [3:0]             pre_cnt;
    logic                   ext_done;
    logic                   del_done;
    logic [FDTC_THR_W-1:0]  inj_cnt;
    logic                   shot_done;
    fdtc_tm_t               tm_act;
    fdtc_ic_t               ic_act;
    logic [FDTC_PAIR_W-1:0] pair;
    logic                   pair_on;
    fdtc_tm_t               tm_reg;
    fdtc_ic_t               ic_reg;
    logic [FDTC_THR_W-1:0]  thr;
    logic [FDTC_SYM_W-1:0]  inja;
    logic [FDTC_SYM_W-1:0]  injb;
    logic                   se;
    logic                   plain;
    logic [31:0]            prdata;
  } fdtc_state_t;

  localparam fdtc_state_t FDTC_STATE_RST = '{tm_act: FDTC_TM_RST, tm_reg: FDTC_TM_RST, ic_act: FDTC_IC_RST,
                                             ic_reg: FDTC_IC_RST, rf_st: FDTC_RF_IDLE, shot_done: 1'b1,
                                             se: FDTC_SE_RST, plain: FDTC_PLAIN_RST, default: '0};

  function automatic logic fdtc_sym_ok(input logic [4:0] s);
    return (s inside {5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d}) ||
           (s inside {FDTC_SYM_I, FDTC_SYM_J, FDTC_SYM_K, FDTC_SYM_T, FDTC_SYM_R, FDTC_SYM_S,
                      FDTC_SYM_H, FDTC_SYM_Q});
  endfunction

  function automatic logic fdtc_mapped(input logic [7:0] a);
    return a inside {FDTC_OFS_TXSTATE, FDTC_OFS_INJCTL, FDTC_OFS_THRESH, FDTC_OFS_INJA,
                     FDTC_OFS_INJB, FDTC_OFS_MODE, FDTC_OFS_STATUS};
  endfunction
endpackage

// ==== core/fdtc_serializer.sv ====
// Symbol-pair shift register with optional NRZI line coding
`timescale 1ns/1ps
module fdtc_serializer
  import fdtc_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   local_byte_clock,
  input  wire logic [FDTC_PAIR_W-1:0] pair,
  input  wire logic                   pair_on,
  input  wire logic                   plain_serial_select,
  output logic                        tx_serial_data,
  output logic                        pmd_tx_enable
);
  typedef struct packed {
    logic [FDTC_PAIR_W-1:0] sh;
    logic                   lvl;
    logic                   en;
  } fdtc_ser_t;

  fdtc_ser_t s;
  fdtc_ser_t n;
  logic      bit_now;

  // The bit clock is sys_clk itself; one pair lasts exactly ten of its cycles
  always_comb begin
    n = s;
    if (local_byte_clock) begin
      n.sh = pair;
      n.en = pair_on;
    end else begin
      n.sh = {s.sh[FDTC_PAIR_W-2:0], 1'b0};
    end
    bit_now = n.sh[FDTC_PAIR_W-1];
    if (plain_serial_select) begin
      n.lvl = bit_now;
    end else begin
      n.lvl = s.lvl ^ bit_now;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tx_serial_data = s.lvl;
  assign pmd_tx_enable  = s.en;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_nrzi_toggle: assert property (!plain_serial_select && local_byte_clock |=>
    tx_serial_data == ($past(tx_serial_data) ^ $past(pair[FDTC_PAIR_W-1])))
    else $error("NRZI level did not follow the first bit of the pair");
  a_plain_follow: assert property (plain_serial_select && local_byte_clock ##1 plain_serial_select |->
    tx_serial_data == $past(pair[FDTC_PAIR_W-1]) ##1 tx_serial_data == $past(pair[FDTC_PAIR_W-2], 2))
    else $error("Plain serial output did not follow the pair bits");
endmodule

// ==== core/fdtc_tx_conditioner.sv ====
// FDDI transmit conditioner: repeat filter, smoother, line states, injection, serial out
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module fdtc_tx_conditioner
  import fdtc_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [FDTC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   in_valid,
  input  wire logic [FDTC_SYM_W-1:0]  in_sym_a,
  input  wire logic [FDTC_SYM_W-1:0]  in_sym_b,
  output logic                        in_ready,
  output logic                        tx_serial_data,
  output logic                        pmd_tx_enable
);
  localparam logic [FDTC_PAIR_W-1:0] PAIR_II = {FDTC_SYM_I, FDTC_SYM_I};
  localparam logic [FDTC_PAIR_W-1:0] PAIR_JK = {FDTC_SYM_J, FDTC_SYM_K};
  localparam logic [FDTC_PAIR_W-1:0] PAIR_HH = {FDTC_SYM_H, FDTC_SYM_H};
  localparam logic [FDTC_PAIR_W-1:0] PAIR_QQ = {FDTC_SYM_Q, FDTC_SYM_Q};
  localparam logic [FDTC_PAIR_W-1:0] PAIR_HQ = {FDTC_SYM_H, FDTC_SYM_Q};

  fdtc_state_t            s;
  fdtc_state_t            n;
  logic                   first;
  logic                   take;
  logic [FDTC_SYM_W-1:0]  sa;
  logic [FDTC_SYM_W-1:0]  sb;
  logic                   is_jk;
  logic                   has_i;
  logic                   has_t;
  logic                   has_rs;
  logic                   viol;
  fdtc_rf_t               rf_nxt;
  logic [FDTC_PAIR_W-1:0] rf_out;
  logic [FDTC_PAIR_W-1:0] sm_out;
  logic [FDTC_PAIR_W-1:0] lsg;
  logic                   smooth;
  logic                   ext_now;
  logic                   del_now;
  logic                   out_jk;
  logic                   inj_hit;
  logic                   acc;
  logic                   mapped;

  function automatic logic [31:0] rd_word(input logic [FDTC_ADDR_W-1:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      FDTC_OFS_TXSTATE: w[FDTC_TM_LSB +: FDTC_TM_W] = s.tm_reg;
      FDTC_OFS_INJCTL:  w[FDTC_IC_LSB +: FDTC_IC_W] = s.ic_reg;
      FDTC_OFS_THRESH:  w[FDTC_THR_W-1:0] = s.thr;
      FDTC_OFS_INJA:    w[FDTC_SYM_W-1:0] = s.inja;
      FDTC_OFS_INJB:    w[FDTC_SYM_W-1:0] = s.injb;
      FDTC_OFS_MODE: begin
        w[FDTC_SE_BIT]    = s.se;
        w[FDTC_PLAIN_BIT] = s.plain;
      end
      FDTC_OFS_STATUS: begin
        w[FDTC_ST_RF_LSB +: 2]          = s.rf_st;
        w[FDTC_ST_CNT_LSB +: 4]         = s.pre_cnt;
        w[FDTC_ST_TM_LSB +: FDTC_TM_W]  = s.tm_act;
        w[FDTC_ST_IC_LSB +: FDTC_IC_W]  = s.ic_act;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  always_comb begin
    n      = s;
    first  = (s.slot == FDTC_SLOT_FIRST);
    take   = first || ((s.slot == FDTC_SLOT_REDO) && s.redo);
    // A starved input is repeated as idle so the line never underruns
    sa     = in_valid ? in_sym_a : FDTC_SYM_I;
    sb     = in_valid ? in_sym_b : FDTC_SYM_I;
    is_jk  = ({sa, sb} == PAIR_JK);
    has_i  = (sa == FDTC_SYM_I) || (sb == FDTC_SYM_I);
    has_t  = (sa == FDTC_SYM_T) || (sb == FDTC_SYM_T);
    has_rs = (sa inside {FDTC_SYM_R, FDTC_SYM_S}) || (sb inside {FDTC_SYM_R, FDTC_SYM_S});
    viol   = !(fdtc_sym_ok(sa) && fdtc_sym_ok(sb));

    rf_nxt = s.rf_st;
    rf_out = {sa, sb};
    if (is_jk) begin
      rf_nxt = FDTC_RF_REPEAT;
    end else if (has_i) begin
      rf_nxt = FDTC_RF_IDLE;
      rf_out = PAIR_II;
    end else begin
      case (s.rf_st)
        FDTC_RF_IDLE: rf_out = PAIR_II;
        FDTC_RF_REPEAT: begin
          if (viol || has_rs) begin
            rf_nxt = FDTC_RF_HALT;
            rf_out = PAIR_HH;
          end else if (has_t) begin
            rf_nxt = FDTC_RF_END;
          end
        end
        FDTC_RF_END: begin
          if (viol) begin
            rf_nxt = FDTC_RF_HALT;
            rf_out = PAIR_HH;
          end
        end
        FDTC_RF_HALT: begin
          rf_nxt = FDTC_RF_IDLE;
          rf_out = PAIR_HH;
        end
        default: begin
          rf_nxt = FDTC_RF_IDLE;
          rf_out = PAIR_II;
        end
      endcase
    end

    smooth  = s.se && (s.tm_act == FDTC_TM_ACTIVE);
    ext_now = first && smooth && is_jk && (s.pre_cnt < FDTC_PRE_TARGET) && !s.ext_done;
    del_now = first && smooth && (rf_out == PAIR_II) && (s.pre_cnt >= FDTC_PRE_TARGET) && !s.del_done;
    sm_out  = ext_now ? PAIR_II : rf_out;

    case (s.tm_act)
      FDTC_TM_ACTIVE: lsg = sm_out;
      FDTC_TM_IDLE:   lsg = PAIR_II;
      FDTC_TM_MASTER: lsg = PAIR_HQ;
      FDTC_TM_HALT:   lsg = PAIR_HH;
      FDTC_TM_OFF:    lsg = PAIR_QQ;
      FDTC_TM_QUIET:  lsg = PAIR_QQ;
      default:        lsg = PAIR_QQ;
    endcase

    out_jk = (lsg == PAIR_JK);
    case (s.ic_act)
      FDTC_IC_ONESHOT: begin
        if (out_jk) begin
          inj_hit = ~|s.thr;
        end else begin
          inj_hit = !s.shot_done && (|s.thr) && (s.inj_cnt == s.thr);
        end
      end
      // A count carried over from another mode must not hold off the first hit
      FDTC_IC_PERIODIC: inj_hit = (s.inj_cnt >= s.thr);
      FDTC_IC_CONT:     inj_hit = 1'b1;
      default:          inj_hit = 1'b0;
    endcase

    in_ready = take && !ext_now;

    if (take) begin
      if (!ext_now) begin
        n.rf_st = rf_nxt;
      end
      if (del_now) begin
        // The dropped idle pair is replaced by the next input pair in slot one
        n.redo     = 1'b1;
        n.del_done = 1'b1;
      end else begin
        n.redo    = 1'b0;
        n.pair    = inj_hit ? {s.inja, s.injb} : lsg;
        n.pair_on = (s.tm_act != FDTC_TM_OFF);
        if (sm_out == PAIR_II) begin
          n.pre_cnt = (s.pre_cnt == FDTC_PRE_SAT) ? s.pre_cnt : 4'(s.pre_cnt + 4'h1);
        end else begin
          n.pre_cnt  = '0;
          n.ext_done = 1'b0;
          n.del_done = 1'b0;
        end
        if (ext_now) begin
          n.ext_done = 1'b1;
        end
        case (s.ic_act)
          FDTC_IC_ONESHOT: begin
            if (out_jk) begin
              n.inj_cnt   = FDTC_INJ_ONE;
              n.shot_done = inj_hit;
            end else begin
              n.inj_cnt   = (s.inj_cnt == FDTC_INJ_SAT) ? s.inj_cnt : 8'(s.inj_cnt + FDTC_INJ_ONE);
              n.shot_done = s.shot_done || inj_hit;
            end
          end
          FDTC_IC_PERIODIC: n.inj_cnt = inj_hit ? '0 : 8'(s.inj_cnt + FDTC_INJ_ONE);
          default:          n.inj_cnt = '0;
        endcase
      end
    end

    n.slot = (s.slot == FDTC_SLOT_LAST) ? FDTC_SLOT_FIRST : 4'(s.slot + 4'h1);
    if (s.slot == FDTC_SLOT_LAST) begin
      n.tm_act = s.tm_reg;
      n.ic_act = s.ic_reg;
    end

    acc    = psel && penable;
    mapped = fdtc_mapped(paddr);
    if (acc && pwrite) begin
      case (paddr)
        FDTC_OFS_TXSTATE: n.tm_reg = fdtc_tm_t'(pwdata[FDTC_TM_LSB +: FDTC_TM_W]);
        FDTC_OFS_INJCTL:  n.ic_reg = fdtc_ic_t'(pwdata[FDTC_IC_LSB +: FDTC_IC_W]);
        FDTC_OFS_THRESH:  n.thr    = pwdata[FDTC_THR_W-1:0];
        FDTC_OFS_INJA:    n.inja   = pwdata[FDTC_SYM_W-1:0];
        FDTC_OFS_INJB:    n.injb   = pwdata[FDTC_SYM_W-1:0];
        FDTC_OFS_MODE: begin
          n.se    = pwdata[FDTC_SE_BIT];
          n.plain = pwdata[FDTC_PLAIN_BIT];
        end
        default: n.se = s.se;
      endcase
    end
    // Read data is latched in the setup phase so the access phase needs no wait state
    if (psel && !penable) begin
      n.prdata = rd_word(paddr);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= FDTC_STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  fdtc_serializer u_ser (
    .sys_clk             (sys_clk),
    .sys_rst             (sys_rst),
    .local_byte_clock    (s.slot == FDTC_SLOT_LAST),
    .pair                (s.pair),
    .pair_on             (s.pair_on),
    .plain_serial_select (s.plain),
    .tx_serial_data      (tx_serial_data),
    .pmd_tx_enable       (pmd_tx_enable)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence plain_pass_s;
    (s.tm_act == FDTC_TM_ACTIVE) && (s.ic_act == FDTC_IC_NONE) && !del_now;
  endsequence
  sequence halt_entry_s;
    take && !is_jk && !has_i && (s.rf_st == FDTC_RF_REPEAT) && viol;
  endsequence
  sequence halt_second_s;
    take && !is_jk && !has_i && (s.rf_st == FDTC_RF_HALT);
  endsequence

  a_jk_repeat: assert property (take && in_ready && is_jk |=> s.rf_st == FDTC_RF_REPEAT)
    else $error("JK did not enter repeat");
  a_idle_enter: assert property (take && in_ready && !is_jk && has_i |=> s.rf_st == FDTC_RF_IDLE)
    else $error("Idle symbol did not enter idle");
  a_halt_first: assert property (halt_entry_s ##0 plain_pass_s |=>
    (s.rf_st == FDTC_RF_HALT) && (s.pair == PAIR_HH) && (s.slot == FDTC_SLOT_REDO))
    else $error("Violation did not start halt pairs");
  a_halt_second: assert property (halt_second_s ##0 plain_pass_s |=>
    (s.rf_st == FDTC_RF_IDLE) && (s.pair == PAIR_HH))
    else $error("Second halt pair missing");
  a_rs_violate: assert property (take && (s.rf_st == FDTC_RF_REPEAT) && has_rs && !is_jk && !has_i
    |=> s.rf_st == FDTC_RF_HALT)
    else $error("R or S before T not treated as violation");
  a_extend_pair: assert property (ext_now ##0 plain_pass_s |-> !in_ready ##1
    (s.pair == PAIR_II) && s.ext_done ##9 in_ready)
    else $error("Extend did not hold JK for one idle pair");
  a_delete_redo: assert property (del_now |=> s.redo && (s.slot == FDTC_SLOT_REDO) && in_ready)
    else $error("Delete did not take a replacement pair");
  a_mode_edge: assert property ((s.tm_act != $past(s.tm_act)) || (s.ic_act != $past(s.ic_act))
    |-> s.slot == FDTC_SLOT_FIRST)
    else $error("Mode changed inside a pair");
  a_halt_mode: assert property (take && !del_now && (s.tm_act == FDTC_TM_HALT) &&
    (s.ic_act == FDTC_IC_NONE) |=> s.pair == PAIR_HH)
    else $error("Halt mode did not send halt pairs");
  a_rsvd_quiet: assert property (take && !del_now && (s.tm_act inside {FDTC_TM_RSVD, FDTC_TM_RSVD2}) &&
    (s.ic_act == FDTC_IC_NONE) |=> s.pair == PAIR_QQ)
    else $error("Reserved mode did not send quiet");
  a_cont_inject: assert property (take && !del_now && (s.ic_act == FDTC_IC_CONT)
    |=> s.pair == {$past(s.inja), $past(s.injb)})
    else $error("Continuous injection missed a pair");
  a_off_disable: assert property ((s.tm_act == FDTC_TM_OFF) && take && first && !del_now
    |-> ##10 !pmd_tx_enable)
    else $error("Off mode left the PMD transmitter enabled");
endmodule

// ==== test/fdtc_pmd_model.sv ====
// Far-side receiver model: recovers symbol pairs from the serial line and samples pmd_tx_enable once per pair
`timescale 1ns/1ps
module fdtc_pmd_model
  import fdtc_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   tx_serial_data,
  input  wire logic                   pmd_tx_enable,
  input  wire logic                   plain_serial_select,
  output logic                        rx_valid,
  output logic [FDTC_PAIR_W-1:0]      rx_pair,
  output logic                        rx_en
);
  logic [3:0]             cnt_r;
  logic [FDTC_PAIR_W-1:0] sh_r;
  logic                   last_r;
  logic                   primed_r;
  logic                   bit_nxt;

  // A one travels as a change of level unless plain coding is chosen
  assign bit_nxt = plain_serial_select ? tx_serial_data : (tx_serial_data ^ last_r);

  // First pair period after reset carries no taken pair, so it is dropped
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r    <= 4'h0;
      sh_r     <= '0;
      last_r   <= 1'b0;
      primed_r <= 1'b0;
      rx_valid <= 1'b0;
      rx_pair  <= '0;
      rx_en    <= 1'b0;
    end else begin
      last_r   <= tx_serial_data;
      sh_r     <= {sh_r[FDTC_PAIR_W-2:0], bit_nxt};
      cnt_r    <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
      rx_valid <= (cnt_r == 4'h9) && primed_r;
      if (cnt_r == 4'h0) begin
        rx_en <= pmd_tx_enable;
      end
      if (cnt_r == 4'h9) begin
        rx_pair  <= {sh_r[FDTC_PAIR_W-2:0], bit_nxt};
        primed_r <= 1'b1;
      end
    end
  end
endmodule

// ==== test/fdtc_tx_conditioner_tb_top.sv ====
// Self-checking bench for the transmit conditioner
`timescale 1ns/1ps
module fdtc_tx_conditioner_tb_top
  import fdtc_pkg::*;
;
  typedef struct {logic [9:0] src; logic [9:0] exp; logic en; bit chk;} fdtc_rec_t;
  localparam logic [9:0] II = {FDTC_SYM_I, FDTC_SYM_I};
  localparam logic [9:0] JK = {FDTC_SYM_J, FDTC_SYM_K};
  localparam logic [9:0] HH = {FDTC_SYM_H, FDTC_SYM_H};
  localparam logic [9:0] QQ = {FDTC_SYM_Q, FDTC_SYM_Q};
  localparam logic [9:0] HQ = {FDTC_SYM_H, FDTC_SYM_Q};
  localparam logic [9:0] RS = {FDTC_SYM_R, FDTC_SYM_S};
  localparam logic [9:0] MEXP [8] = '{QQ, QQ, II, HQ, QQ, QQ, HH, QQ};
  localparam logic [4:0] DSYM [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                       5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic        sys_clk = 1'b0;
  logic        sys_rst, psel, penable, pwrite, in_valid, pready, pslverr, in_ready;
  logic        tx_serial_data, pmd_tx_enable, plain_sel, rx_valid, rx_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0]  in_sym_a, in_sym_b, ia, ib;
  logic [9:0]  rx_pair, d;
  int          n_mismatch, comparisons, pend, pre_run, seed, i;
  int          pre_q[$];
  fdtc_rec_t   src_q[$], exp_q[$], cur, r;
  fdtc_rec_t   fill = '{II, II, 1'b1, 1'b0};

  always #2 sys_clk = ~sys_clk;

  fdtc_tx_conditioner u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_sym_a(in_sym_a), .in_sym_b(in_sym_b), .in_ready(in_ready),
    .tx_serial_data(tx_serial_data), .pmd_tx_enable(pmd_tx_enable));
  fdtc_pmd_model u_pmd (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_serial_data(tx_serial_data),
    .pmd_tx_enable(pmd_tx_enable), .plain_serial_select(plain_sel), .rx_valid(rx_valid),
    .rx_pair(rx_pair), .rx_en(rx_en));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want, input logic ew);
    logic [31:0] x;
    logic        e;
    apb(1'b0, a, 32'h0, x, e);
    check(x, want);
    check(e, ew);
  endtask

  function automatic logic [4:0] ds();
    return DSYM[$unsigned($random(seed)) % 16];
  endfunction

  task automatic feed(input logic [9:0] s, input logic [9:0] e, input logic en, input bit c);
    src_q.push_back('{s, e, en, c});
    if (c) pend++;
  endtask

  // Waits for checked pairs to land, writes, then pads one pair so the change settles first
  task automatic cfg(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    logic        e;
    while (pend > 0 || src_q.size() > 0) @(posedge sys_clk);
    apb(1'b1, a, v, x, e);
    feed(II, II, 1'b1, 1'b0);
  endtask

  task automatic frames();
    feed(JK, JK, 1'b1, 1);
    repeat (2) begin
      d = {ds(), ds()};
      feed(d, d, 1'b1, 1);
    end
    feed({5'h01, 5'h01}, HH, 1'b1, 1);
    feed({ds(), ds()}, HH, 1'b1, 1);
    feed({ds(), ds()}, II, 1'b1, 1);
    feed(JK, JK, 1'b1, 1);
    feed({ds(), FDTC_SYM_R}, HH, 1'b1, 1);
    feed(JK, JK, 1'b1, 1);
    d = {ds(), FDTC_SYM_T};
    feed(d, d, 1'b1, 1);
    feed(RS, RS, 1'b1, 1);
    feed(II, II, 1'b1, 1);
  endtask

  // Drives the next pair whenever one is taken and notes what must come out for it
  always @(posedge sys_clk) begin
    if (!sys_rst && in_ready === 1'b1) begin
      exp_q.push_back(cur);
      cur = (src_q.size() > 0) ? src_q.pop_front() : fill;
      in_sym_a <= cur.src[9:5];
      in_sym_b <= cur.src[4:0];
    end
  end

  always @(posedge sys_clk) begin
    if (!sys_rst && rx_valid === 1'b1) begin
      if (rx_pair === II) pre_run++;
      else begin
        if (rx_pair === JK) pre_q.push_back(pre_run);
        pre_run = 0;
      end
      if (exp_q.size() > 0) begin
        r = exp_q.pop_front();
        if (r.chk) begin
          check(rx_pair, r.exp);
          check(rx_en, r.en);
          pend--;
        end
      end
    end
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    in_valid = 1'b1;
    in_sym_a = FDTC_SYM_I;
    in_sym_b = FDTC_SYM_I;
    plain_sel = 1'b0;
    seed = 32'he7c2;
    cur = fill;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) feed({ds(), ds()}, QQ, 1'b0, 1);
    rd_chk(FDTC_OFS_MODE, 32'h1, 1'b0);
    rd_chk(FDTC_OFS_TXSTATE, 32'h1, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    for (i = 2; i < 8; i++) begin
      cfg(FDTC_OFS_TXSTATE, i);
      repeat (3) feed({ds(), ds()}, MEXP[i], 1'b1, 1);
    end
    cfg(FDTC_OFS_MODE, 32'h40);
    plain_sel = 1'b1;
    cfg(FDTC_OFS_TXSTATE, 32'h0);
    frames();
    cfg(FDTC_OFS_MODE, 32'h0);
    plain_sel = 1'b0;
    frames();
    ia = ds();
    ib = ds();
    cfg(FDTC_OFS_INJA, ia);
    cfg(FDTC_OFS_INJB, ib);
    cfg(FDTC_OFS_TXSTATE, 32'h4);
    cfg(FDTC_OFS_INJCTL, 32'h3);
    repeat (3) feed({ds(), ds()}, {ia, ib}, 1'b1, 1);
    cfg(FDTC_OFS_TXSTATE, 32'h0);
    cfg(FDTC_OFS_INJCTL, 32'h1);
    feed(JK, {ia, ib}, 1'b1, 1);
    d = {ds(), ds()};
    feed(d, d, 1'b1, 1);
    cfg(FDTC_OFS_THRESH, 32'h2);
    feed(JK, JK, 1'b1, 1);
    d = {ds(), ds()};
    feed(d, d, 1'b1, 1);
    feed({ds(), ds()}, {ia, ib}, 1'b1, 1);
    d = {ds(), ds()};
    feed(d, d, 1'b1, 1);
    cfg(FDTC_OFS_THRESH, 32'h1ff);
    rd_chk(FDTC_OFS_THRESH, 32'hff, 1'b0);
    cfg(FDTC_OFS_THRESH, 32'h0);
    cfg(FDTC_OFS_INJCTL, 32'h2);
    repeat (3) feed({ds(), ds()}, {ia, ib}, 1'b1, 1);
    cfg(FDTC_OFS_INJCTL, 32'h0);
    cfg(FDTC_OFS_MODE, 32'h1);
    pre_q.delete();
    // Output count no longer matches takes here, so only preamble lengths are judged
    feed(JK, JK, 1'b1, 0);
    feed({ds(), FDTC_SYM_T}, II, 1'b1, 0);
    repeat (3) feed(II, II, 1'b1, 0);
    feed(JK, JK, 1'b1, 0);
    feed({ds(), FDTC_SYM_T}, II, 1'b1, 0);
    repeat (9) feed(II, II, 1'b1, 0);
    feed(JK, JK, 1'b1, 0);
    i = 0;
    while (pre_q.size() < 3 && i < 3000) begin
      @(posedge sys_clk);
      i++;
    end
    check(pre_q.size(), 32'h3);
    if (pre_q.size() >= 3) begin
      check(pre_q[1], 32'h4);
      check(pre_q[2], 32'h8);
    end
    wrap_up();
  end
endmodule
